// ### design/spsc_consts.vh
// Constants for the SFR page stack control block
// Function
// - Writing active page changes page used.
// - Reading active page returns full byte.
// - Active page gates only the stack view access.
// - Active page decodes on every page.
// - Control register decodes on every page.
// - Index field picks the viewed stack level.
// - Index zero views the active page.
// - Index one to four view lower levels.
// - Enable bit turns on automatic paging.
// - Interrupt entry pushes, loads interrupt page.
// - Interrupt return pops into active page.
// - Enable clear leaves page and stack alone.
// - Enable is control register bit zero.
// - Push shifts levels down, saves old page.
// - Pop restores level one, shifts up.
// - Push only on entry, pop on return.
// - Stack view read-only, page F, 0xD3.
`ifndef SPSC_CONSTS_VH
`define SPSC_CONSTS_VH
`define SPSC_ADDR_PAGE 8'hA7
`define SPSC_ADDR_CTRL 8'hCF
`define SPSC_ADDR_VIEW 8'hD3
`define SPSC_VIEW_PAGE 8'h0F
`define SPSC_RST_PAGE 8'h00
`define SPSC_RST_CTRL 8'h01
`define SPSC_CTRL_MASK 8'h71
`define SPSC_IDX_HI 6
`define SPSC_IDX_LO 4
`define SPSC_EN_BIT 0
`define SPSC_LEVELS 4
`endif

// ### design/spsc_stack.v
// Four-level page stack below the active page
`timescale 1ns/1ps
`default_nettype none
module spsc_stack
(
  input wire mclk,
  input wire reset,
  input wire ce,
  input wire push,
  input wire pop,
  input wire [7:0] push_data,
  input wire [2:0] sel,
  output wire [7:0] level1,
  output reg [7:0] sel_data
);
  reg [7:0] lvl_r [0:3];
  integer i;
  assign level1 = lvl_r[0];
  // ************************************
  // Shift register
  // ************************************
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      for (i = 0; i < 4; i = i + 1)
        lvl_r[i] <= 8'h00;
    end
    else if (ce)
    begin
      if (push)
      begin
        for (i = 3; i > 0; i = i - 1)
          lvl_r[i] <= lvl_r[i-1];
        lvl_r[0] <= push_data;
      end
      else if (pop)
      begin
        // Bottom keeps its value; no fill source exists
        for (i = 0; i < 3; i = i + 1)
          lvl_r[i] <= lvl_r[i+1];
      end
    end
  end
  // Levels one to four; invalid index reads zero
  always @*
  begin
    case (sel)
      3'h1: sel_data = lvl_r[0];
      3'h2: sel_data = lvl_r[1];
      3'h3: sel_data = lvl_r[2];
      3'h4: sel_data = lvl_r[3];
      default: sel_data = 8'h00;
    endcase
  end
endmodule // spsc_stack
`default_nettype wire

// ### design/spsc_top.v
// SFR page select, page stack control and stack view registers
`timescale 1ns/1ps
`default_nettype none
`include "spsc_consts.vh"
module spsc_top
(
  input wire mclk,
  input wire reset,
  input wire ce,
  input wire [7:0] sfr_addr,
  input wire sfr_wr,
  input wire sfr_rd,
  input wire [7:0] sfr_wdata,
  output reg [7:0] sfr_rdata,
  output wire sfr_hit,
  input wire int_entry,
  input wire [7:0] int_page,
  input wire int_return,
  output wire [7:0] active_page,
  output wire auto_page_enable
);

  // ************************************
  // Registers and next values
  // ************************************
  reg [7:0] page_r;
  reg [7:0] page_nxt;
  reg [7:0] ctrl_r;
  reg [7:0] ctrl_nxt;
  reg [7:0] rdata_nxt;

  // ************************************
  // Internal nets
  // ************************************
  wire [2:0] stack_level_index;
  wire [7:0] level1;
  wire [7:0] lvl_data;
  wire [7:0] view_data;
  wire on_view_page;
  wire hit_page;
  wire hit_ctrl;
  wire hit_view;
  wire wr_page;
  wire wr_ctrl;
  wire do_push;
  wire do_pop;

  // ************************************
  // Functions
  // ************************************
  // Full byte compare; partial decode would alias other SFRs
  function addr_match;
    input [7:0] addr;
    input [7:0] target;
    begin
      addr_match = (addr == target);
    end
  endfunction

  // Reserved control bits never reach a flop
  function [7:0] ctrl_clean;
    input [7:0] wdata;
    begin
      ctrl_clean = wdata & `SPSC_CTRL_MASK;
    end
  endfunction

  // Index zero shows the live page, others the stack
  function [7:0] view_pick;
    input [2:0] idx;
    input [7:0] top;
    input [7:0] lower;
    begin
      if (idx == 3'h0)
        view_pick = top;
      else
        view_pick = lower;
    end
  endfunction

  // ************************************
  // Decode
  // ************************************
  // Unmatched addresses read as zero
  assign hit_page = addr_match(sfr_addr, `SPSC_ADDR_PAGE);
  assign hit_ctrl = addr_match(sfr_addr, `SPSC_ADDR_CTRL);
  // Stack view only answers on the high page
  assign on_view_page = addr_match(page_r, `SPSC_VIEW_PAGE);
  assign hit_view = addr_match(sfr_addr, `SPSC_ADDR_VIEW) &
                    on_view_page;
  assign sfr_hit = hit_page | hit_ctrl | hit_view;
  assign wr_page = sfr_wr & hit_page;
  assign wr_ctrl = sfr_wr & hit_ctrl;

  // ************************************
  // Control fields
  // ************************************
  assign active_page = page_r;
  assign auto_page_enable = ctrl_r[`SPSC_EN_BIT];
  assign stack_level_index = ctrl_r[`SPSC_IDX_HI:`SPSC_IDX_LO];
  // Index five to seven reads zero; nothing moves
  assign view_data = view_pick(stack_level_index, page_r, lvl_data);

  // ************************************
  // Stack events
  // ************************************
  // Entry beats return if both arrive together
  assign do_push = auto_page_enable & int_entry;
  assign do_pop = auto_page_enable & int_return & ~int_entry;

  // ************************************
  // Stack
  // ************************************
  // Four levels below the live page
  spsc_stack u_stack
  (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .push(do_push),
    .pop(do_pop),
    .push_data(page_r),
    .sel(stack_level_index),
    .level1(level1),
    .sel_data(lvl_data)
  );

  // ************************************
  // Page register
  // ************************************
  always @*
  begin
    page_nxt = page_r;
    if (do_push)
    begin
      // Old page moves to level one in the stack
      page_nxt = int_page;
    end
    else if (do_pop)
    begin
      page_nxt = level1;
    end
    else if (wr_page)
    begin
      // A page write that meets a stack move is lost
      page_nxt = sfr_wdata;
    end
  end

  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      page_r <= `SPSC_RST_PAGE;
    end
    else if (ce)
    begin
      page_r <= page_nxt;
    end
  end

  // ************************************
  // Control register
  // ************************************
  always @*
  begin
    ctrl_nxt = ctrl_r;
    if (wr_ctrl)
    begin
      // Reserved bits held at zero whatever is written
      ctrl_nxt = ctrl_clean(sfr_wdata);
    end
  end

  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      ctrl_r <= `SPSC_RST_CTRL;
    end
    else if (ce)
    begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // ************************************
  // Read data
  // ************************************
  always @*
  begin
    rdata_nxt = 8'h00;
    if (hit_page)
    begin
      rdata_nxt = page_r;
    end
    else if (hit_ctrl)
    begin
      rdata_nxt = ctrl_r;
    end
    else if (hit_view)
    begin
      rdata_nxt = view_data;
    end
  end

  // Held between reads so the core may sample late
  always @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      sfr_rdata <= 8'h00;
    end
    else if (ce)
    begin
      if (sfr_rd)
      begin
        sfr_rdata <= rdata_nxt;
      end
    end
  end
endmodule // spsc_top
`default_nettype wire

// ### tb/spsc_properties.sv
// Assertions on the page select, control and stack view registers
`timescale 1ns/1ps
`default_nettype none
module spsc_properties
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_hit,
  input wire logic int_entry,
  input wire logic [7:0] int_page,
  input wire logic int_return,
  input wire logic [7:0] active_page,
  input wire logic auto_page_enable
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire wr_a = ce && sfr_wr && sfr_addr == 8'hA7;
  wire wr_c = ce && sfr_wr && sfr_addr == 8'hCF;
  AST_PAGE_WR: assert property (
    wr_a && !int_entry && !int_return |=> active_page == $past(sfr_wdata))
    else $error("page write lost");
  AST_PAGE_RD: assert property (
    ce && sfr_rd && sfr_addr == 8'hA7 |=> sfr_rdata == $past(active_page))
    else $error("page read wrong");
  AST_HIT_A: assert property (sfr_addr == 8'hA7 |-> sfr_hit)
    else $error("page reg missed");
  AST_HIT_C: assert property (sfr_addr == 8'hCF |-> sfr_hit)
    else $error("ctrl reg missed");
  AST_PUSH: assert property (
    ce && int_entry && auto_page_enable |=> active_page == $past(int_page))
    else $error("entry page wrong");
  AST_OFF: assert property (
    ce && (int_entry || int_return) && !auto_page_enable && !sfr_wr
    |=> $stable(active_page)) else $error("page moved");
  AST_EN: assert property (
    wr_c |=> auto_page_enable == $past(sfr_wdata[0]))
    else $error("enable bit wrong");
  AST_IDX: assert property (
    wr_c ##2 ce && sfr_rd && sfr_addr == 8'hCF
    |=> sfr_rdata == ($past(sfr_wdata, 3) & 8'h71)) else $error("ctrl read");
  AST_RD_HOLD: assert property (
    ce && !sfr_rd |=> $stable(sfr_rdata))
    else $error("read data moved without a read");
  AST_CE_HOLD: assert property (
    !ce |=> $stable(active_page) && $stable(auto_page_enable)
    && $stable(sfr_rdata)) else $error("state moved with ce low");
  AST_HIT_V: assert property (
    sfr_addr == 8'hD3 |-> sfr_hit == (active_page == 8'h0F))
    else $error("view decode wrong");
  AST_VIEW_OFF: assert property (
    ce && sfr_rd && sfr_addr == 8'hD3 && active_page != 8'h0F
    |=> sfr_rdata == 8'h00) else $error("view read off page");
endmodule // spsc_properties
bind spsc_top spsc_properties u_chk
(
  .mclk(mclk),
  .reset(reset),
  .ce(ce),
  .sfr_addr(sfr_addr),
  .sfr_wr(sfr_wr),
  .sfr_rd(sfr_rd),
  .sfr_wdata(sfr_wdata),
  .sfr_rdata(sfr_rdata),
  .sfr_hit(sfr_hit),
  .int_entry(int_entry),
  .int_page(int_page),
  .int_return(int_return),
  .active_page(active_page),
  .auto_page_enable(auto_page_enable)
);
`default_nettype wire

// ### tb/spsc_core.sv
// Core side model: interrupt entry and return strobes
`timescale 1ns/1ps
`default_nettype none
module spsc_core
(
  input wire logic mclk,
  output logic int_entry = 1'h0,
  output logic int_return = 1'h0,
  output logic [7:0] int_page = 8'h00
);
  task pulse(input e, input [7:0] p);
  begin
    {int_entry, int_return, int_page} = {e, !e, p};
    @(negedge mclk);
    {int_entry, int_return, int_page} = {2'h0, ~p}; // Page not held
    @(negedge mclk);
  end
  endtask
endmodule // spsc_core
`default_nettype wire

// ### tb/spsc_tb.sv
// Self-checking bench for the page stack block
`timescale 1ns/1ps
`default_nettype none
module spsc_tb;
  logic mclk = 0, reset = 1, ce = 1, sfr_wr = 0, sfr_rd = 0;
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata, active_page;
  logic sfr_hit, auto_page_enable, int_entry, int_return;
  logic [7:0] int_page;
  int errors = 0, n_compared = 0, cyc = 0;
  always #5 mclk = ~mclk;
  spsc_core core
  (
    .mclk(mclk),
    .int_entry(int_entry),
    .int_return(int_return),
    .int_page(int_page)
  );
  spsc_top dut
  (
    .mclk(mclk),
    .reset(reset),
    .ce(ce),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .sfr_hit(sfr_hit),
    .int_entry(int_entry),
    .int_page(int_page),
    .int_return(int_return),
    .active_page(active_page),
    .auto_page_enable(auto_page_enable)
  );
  // Stack contents after the four pushes, index by index
  function automatic logic [7:0] view_exp(input logic [2:0] k);
  begin
    case (k)
      3'h0: view_exp = 8'h0F;
      3'h1: view_exp = 8'h33;
      3'h2: view_exp = 8'h22;
      3'h3: view_exp = 8'h11;
      3'h4: view_exp = 8'h0F;
      default: view_exp = 8'h00;
    endcase
  end
  endfunction
  task chk(input [7:0] act, input [7:0] exp);
  begin
    n_compared++;
    if (act !== exp)
    begin
      errors++;
      $display("BAD %0t got %h want %h", $time, act, exp);
    end
  end
  endtask
  task acc(input [7:0] a, input w, input [7:0] d);
  begin
    sfr_addr = a;
    sfr_wdata = d;
    {sfr_wr, sfr_rd} = {w, !w};
    @(negedge mclk);
    {sfr_wr, sfr_rd} = 2'h0;
    @(negedge mclk);
    if (!w)
      chk(sfr_rdata, d);
  end
  endtask
  task complete_run;
  begin
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc >= 500)
    begin
      errors++;
      complete_run;
    end
  end
  initial
  begin
    repeat (16) @(negedge mclk);
    reset = 0;
    chk(active_page, 8'h00);
    chk({7'h00, auto_page_enable}, 8'h01);
    acc(8'hA7, 0, 8'h00);
    chk({7'h00, sfr_hit}, 8'h01);
    acc(8'hCF, 0, 8'h01);
    acc(8'hCF, 1, 8'h71);
    acc(8'hCF, 0, 8'h71);
    acc(8'hCF, 1, 8'h01);
    acc(8'hA7, 1, 8'h0F);
    chk(active_page, 8'h0F);
    for (int k = 1; k < 5; k++) core.pulse(1, 8'h11 * k[7:0]);
    chk(active_page, 8'h44);
    acc(8'hA7, 1, 8'h0F);
    for (int k = 0; k < 6; k++)
    begin
      acc(8'hCF, 1, {1'h0, k[2:0], 4'h1});
      acc(8'hD3, 0, view_exp(k[2:0]));
    end
    core.pulse(0, 8'h00);
    acc(8'hA7, 0, 8'h33);
    acc(8'hCF, 1, 8'h00);
    core.pulse(1, 8'h55);
    core.pulse(0, 8'h00);
    acc(8'hA7, 0, 8'h33);
    acc(8'hD3, 0, 8'h00);
    chk({7'h00, sfr_hit}, 8'h00);
    acc(8'hA7, 1, 8'h0F);
    acc(8'hCF, 1, 8'h10);
    acc(8'hD3, 0, 8'h22);
    acc(8'hCF, 1, 8'h40);
    acc(8'hD3, 0, 8'h0F);
    ce = 0;
    acc(8'hA7, 1, 8'h55);
    ce = 1;
    chk(active_page, 8'h0F);
    reset = 1;
    repeat (2) @(negedge mclk);
    reset = 0;
    acc(8'hCF, 0, 8'h01);
    acc(8'hA7, 0, 8'h00);
    complete_run;
  end
endmodule // spsc_tb
`default_nettype wire
